// ### inc/qbsdr_map.svh
// Constants of the four-bank synchronous memory core.
// Assumes inclusion by bare name from design files.
`ifndef QBSDR_MAP_SVH
`define QBSDR_MAP_SVH
`define QBSDR_BANKS        4
`define QBSDR_ROW_BITS     12
`define QBSDR_ADDR_BITS    12
`define QBSDR_COL_MAX_BITS 11
`define QBSDR_COLS_X4      2048
`define QBSDR_COLS_X8      1024
`define QBSDR_COLS_X16     512
`define QBSDR_ROWS         4096
`define QBSDR_AP_BIT       10
`define QBSDR_BL_1         3'h0
`define QBSDR_BL_2         3'h1
`define QBSDR_BL_4         3'h2
`define QBSDR_BL_8         3'h3
`define QBSDR_BL_PAGE      3'h7
`define QBSDR_MEM_COLS     16
`define QBSDR_MEM_ROWS     16
`endif

// ### inc/qbsdr_pkg.sv
// Types of the four-bank synchronous memory core.
// Assumes the map header is compiled alongside.
package qbsdr_pkg;
  typedef enum logic [8:0] {
    QBSDR_CMD_INHIBIT = 9'h001,
    QBSDR_CMD_NOP     = 9'h002,
    QBSDR_CMD_ACT     = 9'h004,
    QBSDR_CMD_READ    = 9'h008,
    QBSDR_CMD_WRITE   = 9'h010,
    QBSDR_CMD_PRE     = 9'h020,
    QBSDR_CMD_STOP    = 9'h040,
    QBSDR_CMD_REF     = 9'h080,
    QBSDR_CMD_MODE    = 9'h100
  } qbsdr_cmd_type;
  typedef enum logic [2:0] {
    QBSDR_IDLE = 3'h1,
    QBSDR_RD   = 3'h2,
    QBSDR_WR   = 3'h4
  } qbsdr_state_type;
  typedef struct packed {
    logic        chip_select_n;
    logic        row_strobe_n;
    logic        col_strobe_n;
    logic        write_enable_n;
    logic        bank_select_msb;
    logic        bank_select_lsb;
    logic [11:0] row_column_addr;
  } qbsdr_cmd_bus_type;
endpackage : qbsdr_pkg

// ### rtl/qbsdr_core.sv
// Behavioural four-bank synchronous memory core with burst engine.
// Assumes a controller on the same clock drives the command pins and write data.
`timescale 1ns/10ps
`include "qbsdr_map.svh"
module qbsdr_core #(
  parameter logic [1:0] WIDTH_MODE = 2'h2  // 0: four, 1: eight, 2: sixteen.
) (
  input  wire logic                      clk,         // System clock.
  input  wire logic                      reset,       // Async, high.
  input  wire qbsdr_pkg::qbsdr_cmd_bus_type cmd_bus,  // Command pins.
  input  wire logic [2:0]                burst_code,  // Burst length code.
  input  wire logic                      power_down,  // Low power request.
  input  wire logic [15:0]               wr_data,     // Write data.
  input  wire logic                      data_mask,   // Data mask.
  output logic [15:0]                    rd_data,     // Read data.
  output logic                           rd_valid,    // Read data valid.
  output logic                           in_power_down, // Power-down state.
  output logic [3:0]                     bank_open,   // Open bank flags.
  output logic [11:0]                    refresh_row  // Next refresh row.
);
  localparam int MC = `QBSDR_MEM_COLS;
  localparam int MR = `QBSDR_MEM_ROWS;

  // Small behavioural storage window indexed by bank, row and column.
  logic [15:0] mem [`QBSDR_BANKS][MR][MC];

  logic [11:0] open_row [`QBSDR_BANKS];
  qbsdr_pkg::qbsdr_state_type state;
  qbsdr_pkg::qbsdr_state_type next_state;
  logic [1:0]  burst_bank;
  logic [10:0] burst_col;
  logic [10:0] burst_base;
  logic [10:0] burst_left;
  logic        burst_ap;
  qbsdr_pkg::qbsdr_cmd_type cmd;

  // Command decode from select and strobes together.
  wire [3:0] strobes = {cmd_bus.chip_select_n, cmd_bus.row_strobe_n,
                        cmd_bus.col_strobe_n, cmd_bus.write_enable_n};
  always_comb begin
    case (strobes)
      4'h0:    cmd = qbsdr_pkg::QBSDR_CMD_MODE;
      4'h1:    cmd = qbsdr_pkg::QBSDR_CMD_REF;
      4'h2:    cmd = qbsdr_pkg::QBSDR_CMD_PRE;
      4'h3:    cmd = qbsdr_pkg::QBSDR_CMD_ACT;
      4'h4:    cmd = qbsdr_pkg::QBSDR_CMD_WRITE;
      4'h5:    cmd = qbsdr_pkg::QBSDR_CMD_READ;
      4'h6:    cmd = qbsdr_pkg::QBSDR_CMD_STOP;
      4'h7:    cmd = qbsdr_pkg::QBSDR_CMD_NOP;
      default: cmd = qbsdr_pkg::QBSDR_CMD_INHIBIT;
    endcase
  end

  // Bank, row and column fields of the address inputs.
  wire [1:0]  cmd_bank = {cmd_bus.bank_select_msb,
                          cmd_bus.bank_select_lsb};
  wire [11:0] cmd_addr = cmd_bus.row_column_addr;
  wire [10:0] col_x4   = {cmd_addr[11], cmd_addr[9:0]};
  wire [10:0] col_x8   = {1'b0, cmd_addr[9:0]};
  wire [10:0] col_x16  = {2'h0, cmd_addr[8:0]};
  wire [10:0] cmd_col  = (WIDTH_MODE == 2'h0) ? col_x4 :
                         (WIDTH_MODE == 2'h1) ? col_x8 : col_x16;
  wire [10:0] page_mask = (WIDTH_MODE == 2'h0) ? 11'h7ff :
                          (WIDTH_MODE == 2'h1) ? 11'h3ff : 11'h1ff;
  wire [15:0] width_mask = (WIDTH_MODE == 2'h0) ? 16'h000f :
                           (WIDTH_MODE == 2'h1) ? 16'h00ff : 16'hffff;
  wire        cmd_ap   = cmd_addr[`QBSDR_AP_BIT];

  // Burst length in locations; codes 4 to 7 give the row's column mask, one less than a full row.
  wire [10:0] burst_len =
    (burst_code == `QBSDR_BL_1) ? 11'h001 :
    (burst_code == `QBSDR_BL_2) ? 11'h002 :
    (burst_code == `QBSDR_BL_4) ? 11'h004 :
    (burst_code == `QBSDR_BL_8) ? 11'h008 : page_mask;
  wire        is_page  = (burst_code == `QBSDR_BL_PAGE);
  wire [10:0] wrap_mask = is_page ? page_mask : (burst_len - 11'h001);

  // Column commands are taken only to a bank with an open row.
  wire col_ok = bank_open[cmd_bank] && !in_power_down;
  wire start_rd = (cmd == qbsdr_pkg::QBSDR_CMD_READ) && col_ok;
  wire start_wr = (cmd == qbsdr_pkg::QBSDR_CMD_WRITE) && col_ok;
  wire stop_cmd = (cmd == qbsdr_pkg::QBSDR_CMD_STOP);
  wire active   = (state != qbsdr_pkg::QBSDR_IDLE);
  wire last_beat = active && (burst_left == 11'h000) && !is_page;
  wire ap_close = active && burst_ap && (last_beat || stop_cmd);

  // Next column wraps within the burst block.
  wire [10:0] step_col = ((burst_col + 11'h001) & wrap_mask) |
                         (burst_base & ~wrap_mask);
  wire [10:0] start_col = (cmd_col & wrap_mask) |
                          (cmd_col & ~wrap_mask);

  wire [11:0] cur_row = open_row[burst_bank];
  wire [3:0]  mem_row = cur_row[3:0];
  wire [3:0]  mem_col = burst_col[3:0];

  // Burst sequencing; a new column command preempts the running burst.
  always_comb begin
    next_state = state;
    if (start_rd) begin
      next_state = qbsdr_pkg::QBSDR_RD;
    end else if (start_wr) begin
      next_state = qbsdr_pkg::QBSDR_WR;
    end else if (stop_cmd || last_beat) begin
      next_state = qbsdr_pkg::QBSDR_IDLE;
    end
    case (next_state)
      qbsdr_pkg::QBSDR_IDLE, qbsdr_pkg::QBSDR_RD,
      qbsdr_pkg::QBSDR_WR: next_state = next_state;
      default:             next_state = qbsdr_pkg::QBSDR_IDLE;
    endcase
  end

  // Burst state registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state      <= qbsdr_pkg::QBSDR_IDLE;
      burst_bank <= 2'h0;
      burst_col  <= 11'h000;
      burst_base <= 11'h000;
      burst_left <= 11'h000;
      burst_ap   <= 1'b0;
    end else begin
      state <= next_state;
      if (start_rd || start_wr) begin
        burst_bank <= cmd_bank;
        burst_col  <= start_col;
        burst_base <= cmd_col;
        burst_left <= burst_len - 11'h001;
        burst_ap   <= cmd_ap;
      end else if (active) begin
        burst_col  <= step_col;
        burst_left <= burst_left - 11'h001;
      end
    end
  end

  // Per-bank open state, so banks act independently.
  genvar b;
  generate
    for (b = 0; b < `QBSDR_BANKS; b++) begin : g_bank
      wire sel  = (cmd_bank == 2'(b));
      wire act  = (cmd == qbsdr_pkg::QBSDR_CMD_ACT) && sel &&
                  !in_power_down;
      wire pre  = (cmd == qbsdr_pkg::QBSDR_CMD_PRE) &&
                  (sel || cmd_addr[`QBSDR_AP_BIT]);
      wire auto = ap_close && (burst_bank == 2'(b));
      // An activate wins over an auto close that ends in the same cycle.
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          bank_open[b] <= 1'b0;
          open_row[b]  <= 12'h000;
        end else if (act) begin
          bank_open[b] <= 1'b1;
          open_row[b]  <= cmd_addr;
        end else if (pre || auto) begin
          bank_open[b] <= 1'b0;
        end
      end
    end
  endgenerate

  // Data path: writes obey the mask, reads drive registered data.
  always_ff @(posedge clk) begin
    if (state == qbsdr_pkg::QBSDR_WR && !data_mask) begin
      mem[burst_bank][mem_row][mem_col] <= wr_data & width_mask;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= (state == qbsdr_pkg::QBSDR_RD) && !data_mask;
      if (state == qbsdr_pkg::QBSDR_RD) begin
        rd_data <= mem[burst_bank][mem_row][mem_col];
      end
    end
  end

  // Refresh row counter and power-down state.
  wire all_idle = (bank_open == 4'h0) && !active;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      refresh_row   <= 12'h000;
      in_power_down <= 1'b0;
    end else begin
      if (cmd == qbsdr_pkg::QBSDR_CMD_REF && all_idle && !in_power_down) begin
        refresh_row <= refresh_row + 12'h001;
      end
      in_power_down <= power_down && (all_idle || in_power_down);
    end
  end

  // Checks on the burst engine and bank state.
  a_col_needs_open: assert property (@(posedge clk) disable iff (reset)
    (cmd == qbsdr_pkg::QBSDR_CMD_READ && !bank_open[cmd_bank])
      |=> !(state == qbsdr_pkg::QBSDR_RD && $changed(burst_base)))
    else $error("Read started on a closed bank.");
  a_burst_four: assert property (@(posedge clk) disable iff (reset)
    (start_rd && burst_code == `QBSDR_BL_4) ##1
      (!start_rd && !start_wr && !stop_cmd)[*4]
      |=> state == qbsdr_pkg::QBSDR_IDLE)
    else $error("Four-beat burst length wrong.");
  a_stop_ends: assert property (@(posedge clk) disable iff (reset)
    (stop_cmd && !start_rd && !start_wr) |=> !active)
    else $error("Terminate did not end burst.");
  a_col_step: assert property (@(posedge clk) disable iff (reset)
    (active && !start_rd && !start_wr) |=> burst_col == $past(step_col))
    else $error("Internal column did not advance.");
  a_ap_close: assert property (@(posedge clk) disable iff (reset)
    ap_close && !(cmd == qbsdr_pkg::QBSDR_CMD_ACT && cmd_bank == burst_bank)
      |=> !bank_open[$past(burst_bank)])
    else $error("Auto precharge left row open.");
  a_act_opens: assert property (@(posedge clk) disable iff (reset)
    (cmd == qbsdr_pkg::QBSDR_CMD_ACT && !in_power_down)
      |=> bank_open[$past(cmd_bank)] && open_row[$past(cmd_bank)] ==
          $past(cmd_addr))
    else $error("Activate did not open row.");
  a_inhibit_hold: assert property (@(posedge clk) disable iff (reset)
    (cmd_bus.chip_select_n && active && !last_beat)
      |=> state == $past(state))
    else $error("Deselect disturbed a burst.");
  a_b2b_column: assert property (@(posedge clk) disable iff (reset)
    start_rd |=> state == qbsdr_pkg::QBSDR_RD && burst_bank == $past(cmd_bank))
    else $error("Read command not taken at once.");

  // Beats done in the current burst, so the total can be held against
  // the programmed length without a long repetition in a property.
  logic [10:0] beat_count;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      beat_count <= 11'h000;
    end else if (start_rd || start_wr) begin
      beat_count <= 11'h001;
    end else if (active) begin
      beat_count <= beat_count + 11'h001;
    end else begin
      beat_count <= 11'h000;
    end
  end

  // Checks on lengths, masking, power-down and independent banks.
  a_beat_total: assert property (@(posedge clk) disable iff (reset)
    (active && !is_page) |-> (beat_count + burst_left) == burst_len)
    else $error("Burst beats and remaining count disagree.");
  a_first_col: assert property (@(posedge clk) disable iff (reset)
    (start_rd || start_wr) |=> burst_col == $past(cmd_col))
    else $error("Burst did not begin at the given column.");
  a_rd_valid_beat: assert property (@(posedge clk) disable iff (reset)
    (state == qbsdr_pkg::QBSDR_RD && !data_mask) |=> rd_valid)
    else $error("Read beat gave no valid data.");
  a_mask_read: assert property (@(posedge clk) disable iff (reset)
    data_mask |=> !rd_valid)
    else $error("Masked read beat shown as valid.");
  a_wr_closed: assert property (@(posedge clk) disable iff (reset)
    (cmd == qbsdr_pkg::QBSDR_CMD_WRITE && !bank_open[cmd_bank] &&
     !active) |=> !active)
    else $error("Write started on a closed bank.");
  a_pre_closes: assert property (@(posedge clk) disable iff (reset)
    (cmd == qbsdr_pkg::QBSDR_CMD_PRE) |=> !bank_open[$past(cmd_bank)])
    else $error("Precharge left its bank open.");
  a_pre_beside: assert property (@(posedge clk) disable iff (reset)
    (cmd == qbsdr_pkg::QBSDR_CMD_PRE && !cmd_addr[`QBSDR_AP_BIT] &&
     cmd_bank != burst_bank && active && !last_beat) |=> active)
    else $error("Precharge of another bank cut a burst.");
  a_pd_no_act: assert property (@(posedge clk) disable iff (reset)
    (cmd == qbsdr_pkg::QBSDR_CMD_ACT && in_power_down)
      |=> bank_open == $past(bank_open))
    else $error("Activate opened a row in power-down.");
  a_pd_no_col: assert property (@(posedge clk) disable iff (reset)
    (in_power_down && (cmd == qbsdr_pkg::QBSDR_CMD_READ ||
                       cmd == qbsdr_pkg::QBSDR_CMD_WRITE)) |=> !active)
    else $error("Column command taken in power-down.");
  a_ref_counts: assert property (@(posedge clk) disable iff (reset)
    (cmd == qbsdr_pkg::QBSDR_CMD_REF && all_idle && !in_power_down)
      |=> refresh_row == $past(refresh_row) + 12'h001)
    else $error("Auto refresh did not advance the row.");
  a_pd_entry: assert property (@(posedge clk) disable iff (reset)
    (power_down && all_idle) |=> in_power_down)
    else $error("Power-down not entered with banks idle.");
  a_pd_exit: assert property (@(posedge clk) disable iff (reset)
    !power_down |=> !in_power_down)
    else $error("Power-down held after the request fell.");
endmodule : qbsdr_core

// ### verif/qbsdr_ctl.sv
// Controller model that issues commands and write data to the core.
// Assumes the bench calls its tasks; clk is the core's own clock.
`timescale 1ns/10ps
module qbsdr_ctl (
  input  wire logic                    clk,     // System clock.
  output qbsdr_pkg::qbsdr_cmd_bus_type cmd_bus, // Command pins.
  output logic [15:0]                  wr_data  // Write data.
);
  // Chip deselected until the first command.
  initial begin
    cmd_bus = '1;
    wr_data = 16'h0000;
  end
  // Drives one command just after an edge; the next edge takes it.
  task automatic cmd(input logic [3:0] code, input logic [1:0] bank,
                     input logic [11:0] addr);
    @(posedge clk);
    #1;
    {cmd_bus.chip_select_n, cmd_bus.row_strobe_n, cmd_bus.col_strobe_n,
     cmd_bus.write_enable_n} = code;
    {cmd_bus.bank_select_msb, cmd_bus.bank_select_lsb} = bank;
    cmd_bus.row_column_addr = addr;
  endtask : cmd
  // No-operation cycles; the row and column address lines toggle, the bank lines stay at 0.
  task automatic idle(input int n);
    repeat (n) cmd(4'h7, 2'h0, ~cmd_bus.row_column_addr);
  endtask : idle
  // Write burst: one data beat on each cycle after the command.
  task automatic wr(input logic [1:0] bank, input logic [11:0] addr,
                    input int beats, input logic [15:0] base);
    cmd(4'h4, bank, addr);
    for (int k = 0; k < beats; k++) begin
      idle(1);
      wr_data = base + 16'(k);
    end
    idle(1);
    wr_data = ~wr_data;
  endtask : wr
endmodule : qbsdr_ctl

// ### verif/tb_quad_bank_sdram_core.sv
// Bench for the four-bank memory core, driven through the controller model.
// Assumes the core at its default sixteen-bit width and no latency option.
`timescale 1ns/10ps
module tb_quad_bank_sdram_core;
  localparam int LIMIT = 3000;  // Cycle ceiling; the tests need about 240.
  logic                         clk;
  logic                         reset;
  qbsdr_pkg::qbsdr_cmd_bus_type cmd_bus;
  logic [2:0]                   burst_code;
  logic                         power_down;
  logic                         data_mask;
  logic [15:0]                  wr_data;
  logic [15:0]                  rd_data;
  logic                         rd_valid;
  logic                         in_power_down;
  logic [3:0]                   bank_open;
  logic [11:0]                  refresh_row;
  int                           errors;
  int                           check_count;
  int                           cycles;
  logic [15:0]                  got[$];
  logic [15:0]                  wrap_exp[4];

  qbsdr_core qbsdr_core_inst (.clk(clk), .reset(reset), .cmd_bus(cmd_bus),
    .burst_code(burst_code), .power_down(power_down), .wr_data(wr_data),
    .data_mask(data_mask), .rd_data(rd_data), .rd_valid(rd_valid),
    .in_power_down(in_power_down), .bank_open(bank_open),
    .refresh_row(refresh_row));
  qbsdr_ctl qbsdr_ctl_inst (.clk(clk), .cmd_bus(cmd_bus), .wr_data(wr_data));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Gathers read beats and cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (rd_valid === 1'b1) got.push_back(rd_data);
    if (cycles == LIMIT) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Issues a read and waits long enough for an eight-beat burst.
  task automatic rd(input logic [1:0] bank, input logic [11:0] addr);
    got.delete();
    qbsdr_ctl_inst.cmd(4'h5, bank, addr);
    qbsdr_ctl_inst.idle(12);
  endtask : rd
  task automatic t_open;
    chk("idle flags", 16'h0, {10'h0, rd_valid, in_power_down, bank_open});
    chk("refresh_row", 16'h0, {4'h0, refresh_row});
    qbsdr_ctl_inst.cmd(4'h3, 2'h2, 12'h005);
    qbsdr_ctl_inst.cmd(4'hb, 2'h1, 12'h003);
    qbsdr_ctl_inst.cmd(4'h0, 2'h0, 12'h000);
    qbsdr_ctl_inst.idle(2);
    chk("bank_open", 16'h0004, {12'h0, bank_open});
    $display("test open done");
  endtask : t_open
  // Write at column 6 wraps in a block of four; the read at column 4 covers the same block unwrapped.
  task automatic t_wrap;
    wrap_exp = '{16'ha0a2, 16'ha0a3, 16'ha0a0, 16'ha0a1};
    burst_code = 3'h2;
    qbsdr_ctl_inst.wr(2'h2, 12'h006, 4, 16'ha0a0);
    rd(2'h2, 12'h004);
    chk("wrap beats", 16'h4, 16'(got.size()));
    for (int k = 0; k < 4; k++) chk("wrap data", wrap_exp[k], got[k]);
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_lengths;
    for (int i = 0; i < 4; i++) begin
      burst_code = 3'(i);
      rd(2'h2, 12'h000);
      chk("burst length", 16'(1 << i), 16'(got.size()));
    end
    burst_code = 3'h7;
    got.delete();
    qbsdr_ctl_inst.cmd(4'h5, 2'h2, 12'h000);
    qbsdr_ctl_inst.cmd(4'he, 2'h2, 12'h000);
    qbsdr_ctl_inst.cmd(4'h6, 2'h2, 12'h000);
    qbsdr_ctl_inst.idle(4);
    chk("beats to stop", 16'h2, 16'(got.size()));
    got.delete();
    qbsdr_ctl_inst.idle(20);
    chk("beats after stop", 16'h0, 16'(got.size()));
    $display("test lengths done");
  endtask : t_lengths
  // Back-to-back reads, then a precharge of bank 1 beside a read of bank 2.
  task automatic t_banks;
    burst_code = 3'h0;
    qbsdr_ctl_inst.cmd(4'h5, 2'h2, 12'h006);
    rd(2'h2, 12'h007);
    chk("back beats", 16'h2, 16'(got.size()));
    chk("back data", 16'ha0a1, {got[0] ^ got[1] ^ 16'ha0a0});
    burst_code = 3'h1;
    qbsdr_ctl_inst.cmd(4'h3, 2'h1, 12'h003);
    got.delete();
    qbsdr_ctl_inst.cmd(4'h5, 2'h2, 12'h004);
    qbsdr_ctl_inst.cmd(4'h2, 2'h1, 12'h000);
    qbsdr_ctl_inst.idle(4);
    chk("overlap beats", 16'h2, 16'(got.size()));
    chk("overlap data", 16'ha0a2, got[0]);
    chk("bank_open", 16'h0004, {12'h0, bank_open});
    rd(2'h1, 12'h004);
    chk("closed bank beats", 16'h0, 16'(got.size()));
    rd(2'h2, 12'h404);
    chk("auto close beats", 16'h2, 16'(got.size()));
    chk("auto close", 16'h0, {12'h0, bank_open});
    $display("test banks done");
  endtask : t_banks
  // Masked write beats leave memory alone; a masked read shows no beats.
  task automatic t_mask;
    burst_code = 3'h1;
    qbsdr_ctl_inst.cmd(4'h3, 2'h2, 12'h005);
    qbsdr_ctl_inst.wr(2'h2, 12'h008, 2, 16'hb0b0);
    data_mask = 1'b1;
    qbsdr_ctl_inst.wr(2'h2, 12'h008, 2, 16'hc0c0);
    rd(2'h2, 12'h008);
    chk("masked read beats", 16'h0, 16'(got.size()));
    data_mask = 1'b0;
    rd(2'h2, 12'h008);
    chk("mask beats", 16'h2, 16'(got.size()));
    chk("mask data 0", 16'hb0b0, got[0]);
    chk("mask data 1", 16'hb0b1, got[1]);
    qbsdr_ctl_inst.cmd(4'h2, 2'h0, 12'h400);
    qbsdr_ctl_inst.idle(1);
    chk("all closed", 16'h0, {12'h0, bank_open});
    $display("test mask done");
  endtask : t_mask
  task automatic t_power;
    qbsdr_ctl_inst.cmd(4'h1, 2'h0, 12'h000);
    qbsdr_ctl_inst.cmd(4'h1, 2'h0, 12'h000);
    qbsdr_ctl_inst.idle(2);
    chk("refresh_row", 16'h2, {4'h0, refresh_row});
    power_down = 1'b1;
    for (int i = 0; i < 20 && in_power_down !== 1'b1; i++)
      qbsdr_ctl_inst.idle(1);
    qbsdr_ctl_inst.cmd(4'h3, 2'h0, 12'h000);
    qbsdr_ctl_inst.cmd(4'h5, 2'h0, 12'h000);
    qbsdr_ctl_inst.idle(2);
    chk("power-down", 16'h10, {11'h0, in_power_down, bank_open});
    power_down = 1'b0;
    $display("test power done");
  endtask : t_power
  // A reset in mid-run closes every bank and clears the refresh count.
  task automatic t_reset;
    qbsdr_ctl_inst.cmd(4'h3, 2'h3, 12'h001);
    qbsdr_ctl_inst.idle(1);
    chk("open before reset", 16'h0008, {12'h0, bank_open});
    reset = 1'b1;
    qbsdr_ctl_inst.idle(2);
    reset = 1'b0;
    chk("reset bank_open", 16'h0, {12'h0, bank_open});
    chk("reset refresh_row", 16'h0, {4'h0, refresh_row});
    qbsdr_ctl_inst.wr(2'h3, 12'h000, 1, 16'hd0d0);
    rd(2'h3, 12'h000);
    chk("closed after reset", 16'h0, 16'(got.size()));
    $display("test reset done");
  endtask : t_reset
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // Reset for 20 cycles, then the scenarios in turn.
  initial begin
    reset = 1'b1;
    power_down = 1'b0;
    data_mask = 1'b0;
    burst_code = 3'h0;
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    t_open();
    t_wrap();
    t_lengths();
    t_banks();
    t_mask();
    t_power();
    t_reset();
    end_of_test();
  end
endmodule : tb_quad_bank_sdram_core
